// File: pkg/scs_pkg.sv
// Shared constants for the scan command sequencer.
// Assumes a single 40 MHz core clock and an external converter front end.
`default_nettype none
package scs_pkg;
  localparam int unsigned clk_mhz = 40;
  localparam logic [3:0] addr_all = 4'hf;
  localparam logic [2:0] cmd_volt = 3'h1;
  localparam logic [2:0] cmd_temp = 3'h2;
  localparam logic [2:0] cmd_mixed = 3'h3;
  localparam logic [2:0] cmd_wire = 3'h4;
  localparam logic [2:0] cmd_all = 3'h5;
  localparam logic [3:0] top_cell = 4'hb;
  localparam logic [3:0] mixed_split = 4'h5;
  localparam logic [3:0] ext_count = 4'h4;
  localparam logic [7:0] scan_count_reset = 8'h00;
  localparam logic [13:0] result_reset = 14'h0000;
  // Input selector codes sent to the converter front end.
  localparam logic [4:0] sel_cell0 = 5'h00;
  localparam logic [4:0] sel_pack = 5'h0c;
  localparam logic [4:0] sel_die = 5'h0d;
  localparam logic [4:0] sel_ext0 = 5'h0e;
  localparam logic [4:0] sel_loop = 5'h12;
  localparam logic [4:0] sel_ref = 5'h13;
  localparam int unsigned n_slots = 20;
  typedef enum logic [3:0] {
    st_idle = 4'b0000,
    st_vcell = 4'b0001,
    st_vpack = 4'b0010,
    st_vdie = 4'b0011,
    st_vwire = 4'b0100,
    st_wire = 4'b0101,
    st_tint = 4'b0110,
    st_text = 4'b0111,
    st_tloop = 4'b1000,
    st_tref = 4'b1001,
    st_mcell = 4'b1010,
    st_mext = 4'b1011,
    st_mpack = 4'b1100,
    st_mdie = 4'b1101,
    st_report = 4'b1110
  } scs_state_t;
endpackage
`default_nettype wire

// File: hw/scs_sequencer.sv
// Scan command sequencer: runs one-shot voltage, temperature, mixed, wire and all scans.
// Assumes a decoded command strobe from the link logic and a converter that answers each
// sample request with a done pulse carrying a result and a limit-fault verdict.
`default_nettype none
module scs_sequencer (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic [3:0] dev_addr,
  input wire logic daisy_chain,
  input wire logic cmd_valid,
  input wire logic [2:0] cmd_code,
  input wire logic [3:0] cmd_addr,
  input wire logic [4:0] otemp_enable,
  output logic conv_start,
  output logic [4:0] conv_sel,
  output logic wire_load,
  input wire logic conv_done,
  input wire logic [13:0] conv_result,
  input wire logic conv_fault,
  input wire logic wire_top_open,
  input wire logic wire_gnd_open,
  input wire logic [4:0] rd_sel,
  output logic [13:0] rd_data,
  output logic [7:0] scan_count,
  output logic [11:0] cell_fault,
  output logic [4:0] temp_fault,
  output logic [12:0] wire_fault,
  output logic fault_n,
  output logic status_resp,
  output logic busy
);
  scs_pkg::scs_state_t state, next_state;
  logic [3:0] idx;
  logic waiting;
  logic all_mode;
  logic resp_pending;
  logic [13:0] result [scs_pkg::n_slots];
  logic [13:0] die_cal;
  logic top_open_meta;
  logic top_open_sync;
  logic gnd_open_meta;
  logic gnd_open_sync;

  // Own address or the broadcast address both select this device.
  wire addr_hit = (cmd_addr == dev_addr) || (cmd_addr == scs_pkg::addr_all);
  wire cmd_known = (cmd_code >= scs_pkg::cmd_volt) && (cmd_code <= scs_pkg::cmd_all);
  wire accept = cmd_valid && addr_hit && cmd_known && (state == scs_pkg::st_idle);
  wire step = waiting && conv_done;
  wire last_idx = (idx == 4'h0);
  wire is_cell_state = (state == scs_pkg::st_vcell) || (state == scs_pkg::st_mcell);
  wire is_temp_state = (state == scs_pkg::st_tint) || (state == scs_pkg::st_text);
  wire [2:0] temp_slot = (state == scs_pkg::st_tint) ? 3'h4 : idx[2:0];
  wire [4:0] ext_sel = scs_pkg::sel_ext0 + {1'b0, idx};

  // Slot chosen for the pending conversion; the mixed scan reuses external slot zero.
  always_comb begin
    case (state)
      scs_pkg::st_vcell, scs_pkg::st_mcell, scs_pkg::st_wire: conv_sel = scs_pkg::sel_cell0 + {1'b0, idx};
      scs_pkg::st_vpack, scs_pkg::st_mpack: conv_sel = scs_pkg::sel_pack;
      scs_pkg::st_vdie, scs_pkg::st_mdie, scs_pkg::st_tint: conv_sel = scs_pkg::sel_die;
      scs_pkg::st_text: conv_sel = ext_sel;
      scs_pkg::st_mext: conv_sel = scs_pkg::sel_ext0;
      scs_pkg::st_tloop: conv_sel = scs_pkg::sel_loop;
      scs_pkg::st_tref: conv_sel = scs_pkg::sel_ref;
      default: conv_sel = scs_pkg::sel_cell0;
    endcase
  end

  assign wire_load = (state == scs_pkg::st_wire);
  assign busy = (state != scs_pkg::st_idle);
  // The result lives in one slot, so both the direct and the all-temperature read reach it.
  assign rd_data = (rd_sel < 5'(scs_pkg::n_slots)) ? result[rd_sel] : scs_pkg::result_reset;

  always_comb begin
    next_state = state;
    case (state)
      scs_pkg::st_idle: begin
        if (accept) begin
          case (cmd_code)
            scs_pkg::cmd_temp: next_state = scs_pkg::st_tint;
            scs_pkg::cmd_mixed: next_state = scs_pkg::st_mcell;
            scs_pkg::cmd_wire: next_state = scs_pkg::st_wire;
            default: next_state = scs_pkg::st_vcell;
          endcase
        end
      end
      scs_pkg::st_vcell: begin
        if (step && last_idx) begin
          next_state = scs_pkg::st_vpack;
        end
      end
      scs_pkg::st_vpack: begin
        if (step) begin
          next_state = scs_pkg::st_vdie;
        end
      end
      scs_pkg::st_vdie: begin
        if (step) begin
          next_state = scs_pkg::st_vwire;
        end
      end
      scs_pkg::st_vwire: begin
        next_state = all_mode ? scs_pkg::st_wire : scs_pkg::st_report;
      end
      scs_pkg::st_wire: begin
        if (step && last_idx) begin
          next_state = all_mode ? scs_pkg::st_tint : scs_pkg::st_report;
        end
      end
      scs_pkg::st_tint: begin
        if (step) begin
          next_state = scs_pkg::st_text;
        end
      end
      scs_pkg::st_text: begin
        if (step && last_idx) begin
          next_state = scs_pkg::st_tloop;
        end
      end
      scs_pkg::st_tloop: begin
        if (step) begin
          next_state = scs_pkg::st_tref;
        end
      end
      scs_pkg::st_tref: begin
        if (step) begin
          next_state = scs_pkg::st_report;
        end
      end
      scs_pkg::st_mcell: begin
        if (step && (idx == scs_pkg::mixed_split + 4'h1)) begin
          next_state = scs_pkg::st_mext;
        end else if (step && last_idx) begin
          next_state = scs_pkg::st_mpack;
        end
      end
      scs_pkg::st_mext: begin
        if (step) begin
          next_state = scs_pkg::st_mcell;
        end
      end
      scs_pkg::st_mpack: begin
        if (step) begin
          next_state = scs_pkg::st_mdie;
        end
      end
      scs_pkg::st_mdie: begin
        if (step) begin
          next_state = scs_pkg::st_vwire;
        end
      end
      scs_pkg::st_report: begin
        next_state = scs_pkg::st_idle;
      end
      default: begin
        next_state = scs_pkg::st_idle;
      end
    endcase
  end

  wire entering = (next_state != state) || accept;
  wire [3:0] next_idx_load =
    (next_state == scs_pkg::st_vcell || next_state == scs_pkg::st_wire) ? scs_pkg::top_cell :
    (next_state == scs_pkg::st_text) ? scs_pkg::ext_count - 4'h1 :
    (next_state == scs_pkg::st_mcell && state == scs_pkg::st_mext) ? scs_pkg::mixed_split :
    (next_state == scs_pkg::st_mcell) ? scs_pkg::top_cell : 4'h0;
  wire needs_conv = (next_state != scs_pkg::st_idle) && (next_state != scs_pkg::st_vwire) &&
                    (next_state != scs_pkg::st_report);
  wire any_fault = (|cell_fault) || (|temp_fault) || (|wire_fault);
  // A state that needs a conversion loads its walk; the counting states step down per answer.
  wire load_walk = entering && needs_conv;
  wire counting_state = (state == scs_pkg::st_vcell) || (state == scs_pkg::st_mcell) ||
                        (state == scs_pkg::st_wire) || (state == scs_pkg::st_text);
  wire walk_down = step && !last_idx && counting_state;
  wire die_step = step && ((state == scs_pkg::st_vdie) || (state == scs_pkg::st_mdie));

  // The open-wire comparators are pins with timing of their own, so they pass two flops
  // first; the lag of two cycles is far shorter than any pass before the check cycle.
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      top_open_meta <= 1'b0;
      top_open_sync <= 1'b0;
      gnd_open_meta <= 1'b0;
      gnd_open_sync <= 1'b0;
    end else begin
      top_open_meta <= wire_top_open;
      top_open_sync <= top_open_meta;
      gnd_open_meta <= wire_gnd_open;
      gnd_open_sync <= gnd_open_meta;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      state <= scs_pkg::st_idle;
      all_mode <= 1'b0;
      scan_count <= scs_pkg::scan_count_reset;
    end else begin
      state <= next_state;
      if (accept) begin
        scan_count <= scan_count + 8'h01;
        all_mode <= (cmd_code == scs_pkg::cmd_all);
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      idx <= 4'h0;
      waiting <= 1'b0;
      conv_start <= 1'b0;
    end else begin
      conv_start <= 1'b0;
      if (load_walk) begin
        idx <= next_idx_load;
        waiting <= 1'b1;
        conv_start <= 1'b1;
      end else if (walk_down) begin
        idx <= idx - 4'h1;
        conv_start <= 1'b1;
      end else if (step) begin
        waiting <= 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      die_cal <= scs_pkg::result_reset;
    end else if (die_step) begin
      die_cal <= conv_result;
    end
  end

  // Faults found mid-scan are only sent on status_resp once the whole pass is over; fault_n falls a cycle after the flag sets.
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      resp_pending <= 1'b0;
      status_resp <= 1'b0;
    end else begin
      status_resp <= 1'b0;
      if (busy && any_fault && daisy_chain) begin
        resp_pending <= 1'b1;
      end
      if (state == scs_pkg::st_report) begin
        status_resp <= resp_pending || (any_fault && daisy_chain);
        resp_pending <= 1'b0;
      end
    end
  end

  // Results stay put until the same input is converted again; the wire scan stores none.
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      for (int i = 0; i < scs_pkg::n_slots; i++) result[i] <= scs_pkg::result_reset;
    end else if (step && state != scs_pkg::st_wire) begin
      result[conv_sel] <= conv_result;
    end
  end

  // Set conditions of the fault flags: one each for the cell and temperature groups, two for the wire group.
  wire cell_hit = step && conv_fault && is_cell_state;
  wire temp_hit = step && conv_fault && is_temp_state && otemp_enable[temp_slot];
  wire pin_hit = step && conv_fault && (state == scs_pkg::st_wire);
  wire end_open = (state == scs_pkg::st_vwire) && (top_open_sync || gnd_open_sync);

  // Fault flags are sticky until reset, so a later clean scan cannot hide an earlier fault.
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      cell_fault <= 12'h000;
      temp_fault <= 5'h00;
      wire_fault <= 13'h0000;
      fault_n <= 1'b1;
    end else begin
      if (cell_hit) begin
        cell_fault[idx] <= 1'b1;
      end
      if (temp_hit) begin
        temp_fault[temp_slot] <= 1'b1;
      end
      if (pin_hit) begin
        wire_fault[idx] <= 1'b1;
      end
      if (end_open) begin
        wire_fault[12] <= 1'b1;
      end
      fault_n <= !any_fault;
    end
  end

  logic unused_die;
  assign unused_die = |die_cal;
endmodule // scs_sequencer
`default_nettype wire

// File: tb/scs_monitor.sv
// Port checker for the scan command sequencer.
// Assumes one clock domain and a bind onto every sequencer instance.
`default_nettype none
module scs_monitor (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic [3:0] dev_addr,
  input wire logic daisy_chain,
  input wire logic cmd_valid,
  input wire logic [2:0] cmd_code,
  input wire logic [3:0] cmd_addr,
  input wire logic conv_start,
  input wire logic wire_load,
  input wire logic [7:0] scan_count,
  input wire logic [11:0] cell_fault,
  input wire logic [4:0] temp_fault,
  input wire logic [12:0] wire_fault,
  input wire logic fault_n,
  input wire logic status_resp,
  input wire logic busy
);
  timeunit 1ns;
  timeprecision 100ps;
  wire logic hit = cmd_valid && !busy && (cmd_addr == dev_addr || cmd_addr == scs_pkg::addr_all);
  wire logic acc = hit && cmd_code >= scs_pkg::cmd_volt && cmd_code <= scs_pkg::cmd_all;
  wire logic flt = |{cell_fault, temp_fault, wire_fault};
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);
  count_step_a: assert property (acc |=> scan_count == $past(scan_count) + 8'h01) else $error("count step");
  ignore_other_a: assert property (cmd_valid && !hit |=> $stable(scan_count)) else $error("count moved");
  start_pass_a: assert property (acc |=> conv_start && busy) else $error("no start");
  idle_quiet_a: assert property (!busy |-> !conv_start && !wire_load) else $error("idle activity");
  scan_ends_a: assert property ($rose(busy) |-> ##[1:1000] !busy) else $error("scan hung");
  fault_pin_a: assert property (flt |=> !fault_n) else $error("fault pin high");
  pin_cause_a: assert property (!fault_n |-> flt) else $error("fault pin without fault");
  resp_pulse_a: assert property (status_resp |-> daisy_chain && flt ##1 !status_resp) else $error("bad resp");
endmodule // scs_monitor
bind scs_sequencer scs_monitor u_scs_monitor (.core_clk(core_clk), .nrst(nrst), .dev_addr(dev_addr),
  .daisy_chain(daisy_chain), .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_addr(cmd_addr),
  .conv_start(conv_start), .wire_load(wire_load), .scan_count(scan_count), .cell_fault(cell_fault),
  .temp_fault(temp_fault), .wire_fault(wire_fault), .fault_n(fault_n), .status_resp(status_resp), .busy(busy));
`default_nettype wire

// File: tb/scs_conv_model.sv
// Converter front-end model with a random answer delay of zero to three cycles.
// Assumes one request at a time; result and fault are junk outside the done pulse.
`default_nettype none
module scs_conv_model (
  input wire logic core_clk,
  input wire logic conv_start,
  input wire logic [4:0] conv_sel,
  input wire logic [4:0] fault_sel,
  output logic conv_done,
  output logic [13:0] conv_result,
  output logic conv_fault
);
  timeunit 1ns;
  timeprecision 100ps;
  int seed = 73;
  int wait_cnt = -1;
  logic [4:0] held_sel = 5'h00;
  initial conv_done = 1'b0;
  initial conv_result = 14'h0000;
  initial conv_fault = 1'b0;
  always @(posedge core_clk) begin
    conv_done <= 1'b0;
    conv_result <= ~conv_result;
    conv_fault <= ~conv_fault;
    if (conv_start) begin
      held_sel <= conv_sel;
      wait_cnt <= {$random(seed)} % 4;
    end else if (wait_cnt == 0) begin
      conv_done <= 1'b1;
      conv_result <= {9'h15a, held_sel};
      conv_fault <= held_sel == fault_sel;
      wait_cnt <= -1;
    end else if (wait_cnt > 0) begin
      wait_cnt <= wait_cnt - 1;
    end
  end
endmodule // scs_conv_model
`default_nettype wire

// File: tb/scan_command_sequencer_test.sv
// Self-checking bench: random scan commands against the sequencer and a converter model.
// Assumes the selector map and walks of the package; results are {9'h15a, selector}.
`default_nettype none
module scan_command_sequencer_test;
  timeunit 1ns;
  timeprecision 100ps;
  typedef logic [5:0] scs_seq_t[$];
  localparam logic [3:0] own_addr = 4'h3;
  logic core_clk = 1'b0, nrst = 1'b0, daisy_chain = 1'b0, cmd_valid = 1'b0, top_open = 1'b0, gnd_open = 1'b0;
  logic [2:0] cmd_code = 3'h0;
  logic [3:0] cmd_addr = 4'h0;
  logic [4:0] otemp_enable = 5'h00, rd_sel = 5'h00, fault_sel = 5'h1f, conv_sel, temp_fault;
  logic conv_start, wire_load, conv_done, conv_fault, fault_n, status_resp, busy;
  logic [13:0] conv_result, rd_data;
  logic [7:0] scan_count;
  logic [11:0] cell_fault;
  logic [12:0] wire_fault;
  int seed = 73, bad_count = 0, total_checks = 0, cycles = 0, resps = 0;
  scs_seq_t got;
  always #12.5 core_clk = ~core_clk;
  scs_sequencer u_scs_sequencer (.core_clk(core_clk), .nrst(nrst), .dev_addr(own_addr), .daisy_chain(daisy_chain),
    .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_addr(cmd_addr), .otemp_enable(otemp_enable),
    .conv_start(conv_start), .conv_sel(conv_sel), .wire_load(wire_load), .conv_done(conv_done),
    .conv_result(conv_result), .conv_fault(conv_fault), .wire_top_open(top_open), .wire_gnd_open(gnd_open),
    .rd_sel(rd_sel), .rd_data(rd_data), .scan_count(scan_count), .cell_fault(cell_fault),
    .temp_fault(temp_fault), .wire_fault(wire_fault), .fault_n(fault_n), .status_resp(status_resp), .busy(busy));
  scs_conv_model u_scs_conv_model (.core_clk(core_clk), .conv_start(conv_start), .conv_sel(conv_sel),
    .fault_sel(fault_sel), .conv_done(conv_done), .conv_result(conv_result), .conv_fault(conv_fault));
  // Sampled mid-cycle so the registered start pulse has settled.
  always @(negedge core_clk) begin
    if (conv_start) got.push_back({wire_load, conv_sel});
    if (status_resp) resps++;
  end
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 40000) begin
      bad_count++;
      give_verdict();
    end
  end
  task automatic check(input logic ok, input string what);
    total_checks++;
    if (ok !== 1'b1) begin
      bad_count++;
      $display("CHECK FAILED at %0t: %s", $time, what);
    end
  endtask
  function automatic scs_seq_t walk(input logic [2:0] c);
    scs_seq_t q;
    logic v = c == scs_pkg::cmd_volt || c == scs_pkg::cmd_mixed || c == scs_pkg::cmd_all;
    for (int i = 11; v && i >= 0; i--) begin
      q.push_back(6'(i));
      if (c == scs_pkg::cmd_mixed && i == 6) q.push_back(6'h0e);
    end
    if (v) q = {q, 6'h0c, 6'h0d};
    for (int i = 11; (c == scs_pkg::cmd_wire || c == scs_pkg::cmd_all) && i >= 0; i--) q.push_back(6'h20 | 6'(i));
    if (c == scs_pkg::cmd_temp || c == scs_pkg::cmd_all) q = {q, 6'h0d, 6'h11, 6'h10, 6'h0f, 6'h0e, 6'h12, 6'h13};
    return q;
  endfunction
  task automatic run_scan(input logic [2:0] c, input logic [3:0] a);
    scs_seq_t want;
    logic [7:0] cnt0 = scan_count;
    logic ok, wf, acc = (a == own_addr || a == scs_pkg::addr_all) && c >= 3'h1 && c <= 3'h5;
    int n = 0;
    if (acc) want = walk(c);
    got.delete();
    resps = 0;
    cmd_code = c;
    cmd_addr = a;
    cmd_valid = 1'b1;
    @(posedge core_clk);
    #2 cmd_valid = 1'b0;
    if (acc && c[0]) begin
      @(posedge core_clk);
      #2 cmd_valid = 1'b1;
      @(posedge core_clk);
      #2 cmd_valid = 1'b0;
    end
    repeat (2) @(posedge core_clk);
    #2;
    while (busy !== 1'b0 && n < 2000) begin
      @(posedge core_clk);
      #2 n++;
    end
    // The report pulse stands in the first standby cycle; let the negedge counter see it first.
    repeat (2) @(posedge core_clk);
    #2 check(busy === 1'b0, "scan finished");
    check(scan_count === cnt0 + 8'(acc), "scan count");
    ok = got.size() == want.size();
    foreach (want[i]) if (got[i] !== want[i]) ok = 1'b0;
    check(ok, "selector walk");
    ok = 1'b0;
    foreach (want[i]) if (want[i] == {1'b0, fault_sel} && fault_sel < 5'h0c) ok = 1'b1;
    if (ok) check(cell_fault[fault_sel] === 1'b1 && fault_n === 1'b0, "cell fault");
    wf = 1'b0;
    foreach (want[i]) if (want[i] == {1'b1, fault_sel} && fault_sel < 5'h0c) wf = 1'b1;
    if (wf) check(wire_fault[fault_sel] === 1'b1 && fault_n === 1'b0, "wire fault");
    if (!daisy_chain || ok || wf) check(resps === ((ok || wf) && daisy_chain), "fault response");
    if (acc && want[0] < 6'h0c && (top_open || gnd_open)) check(wire_fault[12] === 1'b1, "open wire");
    if (acc && !want[0][5]) begin
      rd_sel = want[{$random(seed)} % want.size()][4:0];
      @(posedge core_clk);
      #2 check(rd_data === {9'h15a, rd_sel}, "stored result");
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge core_clk);
    #2 nrst = 1'b1;
    fault_sel = 5'h0d;
    run_scan(scs_pkg::cmd_temp, own_addr);
    check(temp_fault === 5'h00, "disabled compare");
    otemp_enable = 5'h10;
    run_scan(scs_pkg::cmd_temp, scs_pkg::addr_all);
    check(temp_fault[4] === 1'b1 && fault_n === 1'b0, "temp fault");
    for (int i = 0; i < 40; i++) begin
      daisy_chain = 1'($random(seed));
      {top_open, gnd_open} = ({$random(seed)} % 6 == 0) ? 2'($random(seed)) : 2'h0;
      fault_sel = 5'({$random(seed)} % 24);
      otemp_enable = 5'($random(seed));
      run_scan(i < 8 ? 3'(i) : 3'($random(seed)), i < 8 ? own_addr : 4'($random(seed)));
    end
    give_verdict();
  end
endmodule // scan_command_sequencer_test
`default_nettype wire
